// [core/sysctl_cfg.svh]
/*
 * Register offsets, field positions, reset values and timing counts of the
 * system control register slice.
 * Assumes a 10 MHz system clock and a plain address/strobe register port.
 */
`ifndef SYSCTL_CFG_SVH
`define SYSCTL_CFG_SVH

`define SYSCTL_ADDR_W          8
`define SYSCTL_DATA_W          16
`define SYSCTL_OFS_CTRL_ONE    8'h03
`define SYSCTL_OFS_CTRL_TWO    8'h04
`define SYSCTL_OFS_STATUS      8'h40

`define SYSCTL_B_MEM_VALID     5
`define SYSCTL_B_CONFIGURED    4
`define SYSCTL_B_ON_DEB        3
`define SYSCTL_B_ON_PIN_POLARITY        1
`define SYSCTL_B_INTERRUPT_PIN_POLARITY       0

`define SYSCTL_B_SUSP_LOW      15
`define SYSCTL_B_SUSPEND       14
`define SYSCTL_B_ROLE          13
`define SYSCTL_B_HOST_SUPPLY   12
`define SYSCTL_B_HOST_CURR     11
`define SYSCTL_B_LIMIT_BYPASS  10
`define SYSCTL_B_DEV_CURR      9
`define SYSCTL_B_WDOG_HIB      7

`define SYSCTL_ON_PIN_POLARITY_RST      1'b1
`define SYSCTL_INTERRUPT_PIN_POLARITY_RST     1'b0

`define SYSCTL_CLK_HZ          10000000
`define SYSCTL_DEB_LONG_S      10
`define SYSCTL_DEB_SHORT_S     5
`define SYSCTL_DEB_LONG_CYC    (`SYSCTL_DEB_LONG_S * `SYSCTL_CLK_HZ)
`define SYSCTL_DEB_SHORT_CYC   (`SYSCTL_DEB_SHORT_S * `SYSCTL_CLK_HZ)

`endif

// [core/sysctl_pkg.sv]
/*
 * Types shared by the system control register slice.
 * Assumes sysctl_cfg.svh is on the include path.
 */
package sysctl_pkg;

    typedef enum logic [1:0] {
        SYSCTL_ON_IDLE,
        SYSCTL_ON_COUNT,
        SYSCTL_ON_FIRED
    } sysctl_on_e;

    typedef struct packed {
        logic        mem_valid;
        logic        configured;
        logic        on_debounce_select;
        logic        on_pin_polarity;
        logic        interrupt_pin_polarity;
        logic        usb_suspend_low_current;
        logic        usb_suspend;
        logic        usb_role_select;
        logic        usb_host_supply_select;
        logic        usb_host_current_select;
        logic        usb_limit_bypass;
        logic        usb_device_current_select;
        logic        watchdog_in_hibernate;
        logic [15:0] rdata;
        sysctl_on_e  on_state;
        logic [29:0] on_count;
        logic        on_shutdown;
        logic        irq_pin;
        logic        usb_switch_open;
        logic        usb_low_current;
        logic        usb_host_mode;
        logic        usb_host_from_line;
        logic        usb_500ma;
        logic        usb_no_limit;
        logic        watchdog_hib_enable;
    } sysctl_state_s;

endpackage

// [core/sysctl_regs.sv]
/*
 * System control register slice: the memory-valid and configured flags, ON
 * pin debounce and polarity, IRQ pin polarity, and the USB supply controls.
 * Assumes the register port, state machine events and pins are synchronous to
 * clk, and that the security key state arrives as a level from elsewhere.
 */
// How it works
// - Memory-valid flag clears at startup and on state-machine memory reset.
// - In hibernate, memory-valid clears only if the memory reset pin is asserted.
// - Spare configured flag at bit 4, no effect, cleared only by power-on.
// - ON shutdown debounce is 10 s when select is zero, 5 s when one.
// - ON pin active high when polarity is zero, low when one; default one.
// - IRQ pin active low when polarity is zero (default), high when one.
// - Debounce and ON polarity writes need key unlocked; polarity resets by machine.
// - Bit 15 set places USB in low-current suspend.
// - Bit 14 set opens the USB power switch.
// - Suspend bits and device current clear on reset, undervoltage, failed boot.
// - Bit 13 selects role, one is host; clears on host-to-device change.
// - Bit 12 picks host supply: zero converter, one line; machine reset.
// - Bit 11 sets host current 100 mA or 500 mA; machine reset.
// - Bit 10 set removes USB current limit; clear limits as configured.
// - Bit 9 sets device current 100 mA or 500 mA; machine reset.
// - Bit 7 keeps watchdog running in hibernate; clear disables it there.
// - Memory-valid flag sits at bit 5 of the first control word.
`timescale 1ns/1ps
`include "sysctl_cfg.svh"

module sysctl_regs
    import sysctl_pkg::*;
#(
    parameter int unsigned DEB_LONG_CYC  = `SYSCTL_DEB_LONG_CYC,
    parameter int unsigned DEB_SHORT_CYC = `SYSCTL_DEB_SHORT_CYC
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port.
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [15:0] rdata,
    // Events from the main and USB state machines.
    input  wire logic        sm_reset,
    input  wire logic        mem_reset_assert,
    input  wire logic        hibernate,
    input  wire logic        mem_reset_pin_hibernate_state,
    input  wire logic        line_uvlo,
    input  wire logic        boot_hyst_fail,
    input  wire logic        usb_host_to_device,
    input  wire logic        key_unlocked,
    // Pins and internal requests.
    input  wire logic        on_pin,
    input  wire logic        irq_request,
    output logic             irq_pin,
    output logic             on_shutdown,
    // USB switch and watchdog controls.
    output logic             usb_switch_open,
    output logic             usb_low_current,
    output logic             usb_host_mode,
    output logic             usb_host_from_line,
    output logic             usb_500ma,
    output logic             usb_no_limit,
    output logic             watchdog_hib_enable
);

    sysctl_state_s st_ff;
    sysctl_state_s nxt_st;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic        on_active;
    logic [29:0] deb_limit;
    logic        wr_one;
    logic        wr_two;

    assign on_active = on_pin ^ st_ff.on_pin_polarity;
    assign deb_limit = st_ff.on_debounce_select ? 30'(DEB_SHORT_CYC)
                                                : 30'(DEB_LONG_CYC);
    assign wr_one    = wr_stb && hit(addr, `SYSCTL_OFS_CTRL_ONE);
    assign wr_two    = wr_stb && hit(addr, `SYSCTL_OFS_CTRL_TWO);

    always_comb begin
        nxt_st = st_ff;

        // Software writes land first so hardware clears below take priority.
        if (wr_one) begin
            nxt_st.mem_valid  = wdata[`SYSCTL_B_MEM_VALID];
            nxt_st.configured = wdata[`SYSCTL_B_CONFIGURED];
            nxt_st.interrupt_pin_polarity = wdata[`SYSCTL_B_INTERRUPT_PIN_POLARITY];
            if (key_unlocked) begin
                nxt_st.on_debounce_select = wdata[`SYSCTL_B_ON_DEB];
                nxt_st.on_pin_polarity    = wdata[`SYSCTL_B_ON_PIN_POLARITY];
            end
        end
        if (wr_two) begin
            nxt_st.usb_suspend_low_current   = wdata[`SYSCTL_B_SUSP_LOW];
            nxt_st.usb_suspend               = wdata[`SYSCTL_B_SUSPEND];
            nxt_st.usb_role_select           = wdata[`SYSCTL_B_ROLE];
            nxt_st.usb_host_supply_select    = wdata[`SYSCTL_B_HOST_SUPPLY];
            nxt_st.usb_host_current_select   = wdata[`SYSCTL_B_HOST_CURR];
            nxt_st.usb_limit_bypass          = wdata[`SYSCTL_B_LIMIT_BYPASS];
            nxt_st.usb_device_current_select = wdata[`SYSCTL_B_DEV_CURR];
            nxt_st.watchdog_in_hibernate     = wdata[`SYSCTL_B_WDOG_HIB];
        end

        // In hibernate the memory reset pin follows its hibernate setting.
        if (hibernate ? !mem_reset_pin_hibernate_state : mem_reset_assert) begin
            nxt_st.mem_valid = 1'b0;
        end
        if (sm_reset) begin
            nxt_st.mem_valid                 = 1'b0;
            nxt_st.on_pin_polarity           = `SYSCTL_ON_PIN_POLARITY_RST;
            nxt_st.interrupt_pin_polarity    = `SYSCTL_INTERRUPT_PIN_POLARITY_RST;
            nxt_st.usb_role_select           = 1'b0;
            nxt_st.usb_host_supply_select    = 1'b0;
            nxt_st.usb_host_current_select   = 1'b0;
            nxt_st.usb_device_current_select = 1'b0;
        end
        if (sm_reset || line_uvlo || boot_hyst_fail) begin
            nxt_st.usb_suspend_low_current   = 1'b0;
            nxt_st.usb_suspend               = 1'b0;
            nxt_st.usb_device_current_select = 1'b0;
        end
        if (usb_host_to_device) begin
            nxt_st.usb_role_select = 1'b0;
        end

        nxt_st.rdata = 16'h0000;
        if (rd_stb && hit(addr, `SYSCTL_OFS_CTRL_ONE)) begin
            nxt_st.rdata[`SYSCTL_B_MEM_VALID]  = st_ff.mem_valid;
            nxt_st.rdata[`SYSCTL_B_CONFIGURED] = st_ff.configured;
            nxt_st.rdata[`SYSCTL_B_ON_DEB]     = st_ff.on_debounce_select;
            nxt_st.rdata[`SYSCTL_B_ON_PIN_POLARITY]     = st_ff.on_pin_polarity;
            nxt_st.rdata[`SYSCTL_B_INTERRUPT_PIN_POLARITY]    = st_ff.interrupt_pin_polarity;
        end else if (rd_stb && hit(addr, `SYSCTL_OFS_CTRL_TWO)) begin
            nxt_st.rdata[`SYSCTL_B_SUSP_LOW]     = st_ff.usb_suspend_low_current;
            nxt_st.rdata[`SYSCTL_B_SUSPEND]      = st_ff.usb_suspend;
            nxt_st.rdata[`SYSCTL_B_ROLE]         = st_ff.usb_role_select;
            nxt_st.rdata[`SYSCTL_B_HOST_SUPPLY]  = st_ff.usb_host_supply_select;
            nxt_st.rdata[`SYSCTL_B_HOST_CURR]    = st_ff.usb_host_current_select;
            nxt_st.rdata[`SYSCTL_B_LIMIT_BYPASS] = st_ff.usb_limit_bypass;
            nxt_st.rdata[`SYSCTL_B_DEV_CURR]     = st_ff.usb_device_current_select;
            nxt_st.rdata[`SYSCTL_B_WDOG_HIB]     = st_ff.watchdog_in_hibernate;
        end else if (rd_stb && hit(addr, `SYSCTL_OFS_STATUS)) begin
            nxt_st.rdata[0] = st_ff.on_shutdown;
            nxt_st.rdata[1] = on_active;
        end

        // The shutdown request stays high while the pin stays active.
        case (st_ff.on_state)
            SYSCTL_ON_IDLE: begin
                nxt_st.on_count    = 30'h0;
                nxt_st.on_shutdown = 1'b0;
                if (on_active) begin
                    nxt_st.on_state = SYSCTL_ON_COUNT;
                end
            end
            SYSCTL_ON_COUNT: begin
                if (!on_active) begin
                    nxt_st.on_state = SYSCTL_ON_IDLE;
                end else if (st_ff.on_count + 30'h1 >= deb_limit) begin
                    nxt_st.on_state    = SYSCTL_ON_FIRED;
                    nxt_st.on_shutdown = 1'b1;
                end else begin
                    nxt_st.on_count = st_ff.on_count + 30'h1;
                end
            end
            SYSCTL_ON_FIRED: begin
                if (!on_active) begin
                    nxt_st.on_state    = SYSCTL_ON_IDLE;
                    nxt_st.on_shutdown = 1'b0;
                end
            end
            default: begin
                nxt_st.on_state = SYSCTL_ON_IDLE;
            end
        endcase

        nxt_st.irq_pin             = irq_request ^ !st_ff.interrupt_pin_polarity;
        nxt_st.usb_low_current     = st_ff.usb_suspend_low_current;
        nxt_st.usb_switch_open     = st_ff.usb_suspend;
        nxt_st.usb_host_mode       = st_ff.usb_role_select;
        nxt_st.usb_host_from_line  = st_ff.usb_host_supply_select;
        nxt_st.usb_500ma           = st_ff.usb_role_select
                                     ? st_ff.usb_host_current_select
                                     : st_ff.usb_device_current_select;
        nxt_st.usb_no_limit        = st_ff.usb_limit_bypass;
        nxt_st.watchdog_hib_enable = st_ff.watchdog_in_hibernate;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff                        <= '0;
            st_ff.on_pin_polarity        <= `SYSCTL_ON_PIN_POLARITY_RST;
            st_ff.interrupt_pin_polarity <= `SYSCTL_INTERRUPT_PIN_POLARITY_RST;
            st_ff.irq_pin                <= 1'b1;
            st_ff.on_state               <= SYSCTL_ON_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata               = st_ff.rdata;
    assign irq_pin             = st_ff.irq_pin;
    assign on_shutdown         = st_ff.on_shutdown;
    assign usb_switch_open     = st_ff.usb_switch_open;
    assign usb_low_current     = st_ff.usb_low_current;
    assign usb_host_mode       = st_ff.usb_host_mode;
    assign usb_host_from_line  = st_ff.usb_host_from_line;
    assign usb_500ma           = st_ff.usb_500ma;
    assign usb_no_limit        = st_ff.usb_no_limit;
    assign watchdog_hib_enable = st_ff.watchdog_hib_enable;

endmodule

// [dv/sysctl_regs_chk.sv]
/* Checker for the system control register slice.
   Assumes it is bound to sysctl_regs and sees only its ports. */
`timescale 1ns/1ps
module sysctl_regs_chk (
    // Clock, reset and register port.
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [15:0] rdata,
    // Clearing events and pins.
    input wire logic        sm_reset,
    input wire logic        line_uvlo,
    input wire logic        boot_hyst_fail,
    input wire logic        usb_host_to_device,
    input wire logic        irq_request,
    input wire logic        irq_pin,
    // USB controls.
    input wire logic        usb_switch_open,
    input wire logic        usb_low_current,
    input wire logic        usb_host_mode,
    input wire logic        usb_500ma,
    input wire logic        usb_no_limit
);
    logic        pol_ff;
    logic [15:0] wd_ff;
    logic        clr;
    logic        wr_two;
    assign clr    = sm_reset || line_uvlo || boot_hyst_fail || usb_host_to_device;
    assign wr_two = wr_stb && addr == 8'h04;
    // Shadow copies let the output checks know the programmed value.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pol_ff <= 1'b0;
            wd_ff  <= 16'h0000;
        end else begin
            pol_ff <= sm_reset ? 1'b0 : (wr_stb && addr == 8'h03) ? wdata[0] : pol_ff;
            wd_ff  <= wr_two ? wdata : wd_ff;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_w2;
        wr_two && !clr ##1 !wr_two && !clr;
    endsequence
    AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
        else $error("read data not zero outside read slot");
    AST_INTERRUPT_PIN_POLARITY: assert property ($stable(pol_ff) && $stable(irq_request) |->
        irq_pin == (irq_request ^ ~pol_ff))
        else $error("irq pin polarity wrong");
    AST_SUSPEND: assert property (s_w2 |=> usb_switch_open == wd_ff[14])
        else $error("usb switch open wrong");
    AST_LOWCUR: assert property (s_w2 |=> usb_low_current == wd_ff[15])
        else $error("usb low current wrong");
    AST_ROLE: assert property (s_w2 |=> usb_host_mode == wd_ff[13])
        else $error("usb role wrong");
    AST_CURR: assert property (s_w2 |=>
        usb_500ma == (wd_ff[13] ? wd_ff[11] : wd_ff[9]))
        else $error("usb current select wrong");
    AST_NOLIM: assert property (s_w2 |=> usb_no_limit == wd_ff[10])
        else $error("usb limit bypass wrong");
    AST_UVLO: assert property ((line_uvlo || boot_hyst_fail) ##1 !wr_two |=>
        !usb_switch_open && !usb_low_current)
        else $error("suspend not cleared");
    cover property (s_w2);
    cover property (line_uvlo);
    cover property (rd_stb ##1 rdata != 16'h0000);
endmodule

bind sysctl_regs sysctl_regs_chk i_chk (.clk, .sys_rst, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .sm_reset, .line_uvlo, .boot_hyst_fail, .usb_host_to_device, .irq_request,
    .irq_pin, .usb_switch_open, .usb_low_current, .usb_host_mode, .usb_500ma, .usb_no_limit);

// [dv/sysctl_regs_tb.sv]
/* Self-checking bench for the system control register slice.
   Assumes short debounce counts of 20 and 10 cycles. */
`timescale 1ns/1ps
module sysctl_regs_tb;
    logic clk, sys_rst, wr_stb, rd_stb, sm_reset, mem_reset_assert, hibernate, pin_hib;
    logic line_uvlo, boot_hyst_fail, usb_host_to_device, key_unlocked, on_pin, irq_request;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata;
    logic irq_pin, on_shutdown, sw, lc, hm, hl, c5, nl, wh;
    int   failures, tests_run;
    sysctl_regs #(.DEB_LONG_CYC(20), .DEB_SHORT_CYC(10)) i_dut (.clk, .sys_rst, .addr,
        .wdata, .wr_stb, .rd_stb, .rdata, .sm_reset, .mem_reset_assert, .hibernate,
        .mem_reset_pin_hibernate_state(pin_hib), .line_uvlo, .boot_hyst_fail,
        .usb_host_to_device, .key_unlocked, .on_pin, .irq_request, .irq_pin, .on_shutdown,
        .usb_switch_open(sw), .usb_low_current(lc), .usb_host_mode(hm),
        .usb_host_from_line(hl), .usb_500ma(c5), .usb_no_limit(nl),
        .watchdog_hib_enable(wh));
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic final_report();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic t_reset();
        rd(8'h03, 16'h0002);
        rd(8'h04, 16'h0000);
        rd(8'h10, 16'h0000);
        chk("irq_pin", 16'h0001, {15'h0, irq_pin});
    endtask
    task automatic t_usb();
        wr(8'h04, 16'hffff);
        rd(8'h04, 16'hfe80);
        chk("usb_out", 16'h007f, {9'h0, sw, lc, hm, hl, c5, nl, wh});
        wr(8'h04, 16'h0200);
        cyc(2);
        chk("usb_out", 16'h0004, {9'h0, sw, lc, hm, hl, c5, nl, wh});
        wr(8'h04, 16'h2200);
        cyc(2);
        chk("usb_out", 16'h0010, {9'h0, sw, lc, hm, hl, c5, nl, wh});
    endtask
    task automatic t_clears();
        wr(8'h04, 16'hfe80);
        line_uvlo <= 1'b1;
        @(posedge clk) line_uvlo <= 1'b0;
        rd(8'h04, 16'h3c80);
        usb_host_to_device <= 1'b1;
        @(posedge clk) usb_host_to_device <= 1'b0;
        rd(8'h04, 16'h1c80);
        wr(8'h04, 16'hfe80);
        boot_hyst_fail <= 1'b1;
        @(posedge clk) boot_hyst_fail <= 1'b0;
        rd(8'h04, 16'h3c80);
        wr(8'h04, 16'hfe80);
        sm_reset <= 1'b1;
        @(posedge clk) sm_reset <= 1'b0;
        rd(8'h04, 16'h0480);
    endtask
    task automatic t_ctrl_one();
        wr(8'h03, 16'h0039);
        rd(8'h03, 16'h0033);
        irq_request <= 1'b1;
        cyc(3);
        chk("irq_pin", 16'h0001, {15'h0, irq_pin});
        key_unlocked <= 1'b1;
        wr(8'h03, 16'h0038);
        rd(8'h03, 16'h0038);
        chk("irq_pin", 16'h0000, {15'h0, irq_pin});
        sm_reset <= 1'b1;
        @(posedge clk) sm_reset <= 1'b0;
        rd(8'h03, 16'h001a);
        for (int i = 0; i < 3; i++) begin
            // Awake, then hibernate with the pin released, then asserted.
            wr(8'h03, 16'h0038);
            hibernate        <= (i != 0);
            pin_hib          <= (i == 1);
            mem_reset_assert <= 1'b1;
            @(posedge clk) mem_reset_assert <= 1'b0;
            rd(8'h03, (i == 1) ? 16'h0038 : 16'h0018);
        end
        hibernate <= 1'b0;
    endtask
    task automatic t_debounce();
        on_pin <= 1'b0;
        wr(8'h03, 16'h0000);
        @(posedge clk) on_pin <= 1'b1;
        cyc(15);
        chk("on_shutdown", 16'h0000, {15'h0, on_shutdown});
        cyc(10);
        chk("on_shutdown", 16'h0001, {15'h0, on_shutdown});
        on_pin <= 1'b0;
        wr(8'h03, 16'h0008);
        @(posedge clk) on_pin <= 1'b1;
        cyc(6);
        chk("on_shutdown", 16'h0000, {15'h0, on_shutdown});
        cyc(9);
        chk("on_shutdown", 16'h0001, {15'h0, on_shutdown});
        wr(8'h03, 16'h000a);
        cyc(4);
        chk("on_shutdown", 16'h0000, {15'h0, on_shutdown});
        @(posedge clk) on_pin <= 1'b0;
        cyc(15);
        chk("on_shutdown", 16'h0001, {15'h0, on_shutdown});
        rd(8'h40, 16'h0003);
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #400000;
        failures++;
        final_report();
    end
    initial begin
        {sys_rst, on_pin} = 2'b11;
        {wr_stb, rd_stb, sm_reset, mem_reset_assert, hibernate, pin_hib} = 6'h00;
        {line_uvlo, boot_hyst_fail, usb_host_to_device, key_unlocked, irq_request} = 5'h00;
        addr      = 8'h00;
        wdata     = 16'h0000;
        failures  = 0;
        tests_run = 0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_usb();
        t_clears();
        t_ctrl_one();
        t_debounce();
        final_report();
    end
endmodule
